// file: rtl/pdsl_defs.vh
// Offsets, field positions, reset values and counts of the status and link register bank
`ifndef PDSL_DEFS_VH
`define PDSL_DEFS_VH

// ==============================================================
// Configuration access
// ==============================================================
`define PDSL_ADDR_W          12
`define PDSL_OFF_DEV_STATUS  12'h0E8
`define PDSL_OFF_LINK_CAP    12'h0EC
`define PDSL_OFF_LINK_CTRL   12'h0F0

// ==============================================================
// Device error status, upper half of the dword at 0xE8
// ==============================================================
`define PDSL_ST_COR_BIT      16
`define PDSL_ST_NONFATAL_BIT 17
`define PDSL_ST_FATAL_BIT    18
`define PDSL_ST_UNSUP_BIT    19
`define PDSL_ST_AUX_BIT      20
`define PDSL_ST_PEND_BIT     21
`define PDSL_ST_ERR_LSB      16
`define PDSL_ST_ERR_N        4
`define PDSL_ST_AUX_RST      1'h1
`define PDSL_ST_PEND_VAL     1'h0

// ==============================================================
// Link capabilities
// ==============================================================
`define PDSL_CAP_SPEED_LSB   0
`define PDSL_CAP_WIDTH_LSB   4
`define PDSL_CAP_ASPM_LSB    10
`define PDSL_CAP_L0S_LSB     12
`define PDSL_CAP_L1_LSB      15
`define PDSL_CAP_PORT_LSB    24
`define PDSL_CAP_SPEED_VAL   4'h1
`define PDSL_CAP_WIDTH_VAL   6'h01
`define PDSL_CAP_ASPM_RST    2'h1
`define PDSL_CAP_L0S_RST     3'h3
`define PDSL_CAP_L1_RST      3'h0
`define PDSL_CAP_PORT_VAL    8'h00

// ==============================================================
// Link control
// ==============================================================
`define PDSL_LC_ASPM_LSB     0
`define PDSL_LC_RCB_BIT      3
`define PDSL_LC_DISABLE_BIT  4
`define PDSL_LC_RETRAIN_BIT  5
`define PDSL_LC_CCLK_BIT     6
`define PDSL_LC_EXTSYN_BIT   7
`define PDSL_LC_ASPM_RST     2'h0
`define PDSL_LC_RCB_VAL      1'h0

// ==============================================================
// Training sequence counts
// ==============================================================
`define PDSL_CNT_W           13
`define PDSL_FTS_EXT         13'h1000
`define PDSL_TS1_EXT         13'h0400
`define PDSL_FTS_NORM        13'h0080
`define PDSL_TS1_NORM        13'h0010

`endif

// file: rtl/pdsl_regs.v
// Device error status, link capabilities and link control register bank
`include "pdsl_defs.vh"

module pdsl_regs (
	input  wire        clk_sys,
	input  wire        reset,
	// Configuration access port
	input  wire        cfg_wr,
	input  wire        cfg_rd,
	input  wire [11:0] cfg_addr,
	input  wire [3:0]  cfg_be,
	input  wire [31:0] cfg_wdata,
	output reg  [31:0] cfg_rdata,
	output reg         cfg_rd_valid,
	// Error event pulses and the aux power detect level from the core
	input  wire        err_cor,
	input  wire        err_nonfatal,
	input  wire        err_fatal,
	input  wire        err_unsup,
	input  wire        aux_power_det,
	// Capability default loader (serial management port or EEPROM)
	input  wire        cap_load,
	input  wire [1:0]  cap_aspm_in,
	input  wire [2:0]  cap_l0s_in,
	input  wire [2:0]  cap_l1_in,
	// Controls toward the link logic, and error status for the reporting logic
	output reg         aspm_l0s_enable,
	output reg         aspm_l1_enable,
	output reg         rx_l0s_allowed,
	output reg         link_disable,
	output reg         retrain_link,
	output reg         common_clock,
	output reg         ext_synch,
	output reg  [12:0] fts_count,
	output reg  [12:0] ts1_count,
	output reg  [3:0]  err_status
);

	parameter [12:0] FTS_NORM = `PDSL_FTS_NORM;
	parameter [12:0] TS1_NORM = `PDSL_TS1_NORM;

	// ==========================================================
	// Address decode
	// ==========================================================
	function hit;
		input [11:0] addr;
		input [11:0] off;
		begin
			hit = (addr[11:2] == off[11:2]);
		end
	endfunction

	wire sel_status;
	wire sel_cap;
	wire sel_ctrl;
	wire wr_status;
	wire wr_ctrl;

	// Offsets are dword aligned, so the two low address bits are ignored
	assign sel_status = hit(cfg_addr, `PDSL_OFF_DEV_STATUS);
	assign sel_cap    = hit(cfg_addr, `PDSL_OFF_LINK_CAP);
	assign sel_ctrl   = hit(cfg_addr, `PDSL_OFF_LINK_CTRL);
	// Only the byte lane that holds storage can qualify a write
	assign wr_status  = cfg_wr && sel_status && cfg_be[2];
	assign wr_ctrl    = cfg_wr && sel_ctrl && cfg_be[0];

	// ==========================================================
	// Error status
	// ==========================================================
	wire [3:0] err_flags;
	wire [3:0] err_events;

	// Reporting enables are not looked at here on purpose
	assign err_events = {err_unsup, err_fatal, err_nonfatal, err_cor};

	pdsl_sticky_flags #(
		.W (`PDSL_ST_ERR_N)
	) u_err_flags (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.set_pulse (err_events),
		.clr_en    (wr_status),
		.clr_mask  (cfg_wdata[`PDSL_ST_UNSUP_BIT:`PDSL_ST_COR_BIT]),
		.flags     (err_flags)
	);

	reg aux_power;

	always @(posedge clk_sys) begin
		if (reset) begin
			aux_power <= `PDSL_ST_AUX_RST;
		end else begin
			aux_power <= aux_power_det;
		end
	end

	// ==========================================================
	// Link capabilities, defaults replaceable by the loader
	// ==========================================================
	reg [1:0] cap_aspm;
	reg [2:0] cap_l0s;
	reg [2:0] cap_l1;

	always @(posedge clk_sys) begin
		if (reset) begin
			cap_aspm <= `PDSL_CAP_ASPM_RST;
			cap_l0s  <= `PDSL_CAP_L0S_RST;
			cap_l1   <= `PDSL_CAP_L1_RST;
		end else if (cap_load) begin
			// Loader is the only writer; config writes never reach here
			cap_aspm <= cap_aspm_in;
			cap_l0s  <= cap_l0s_in;
			cap_l1   <= cap_l1_in;
		end
	end

	// ==========================================================
	// Link control
	// ==========================================================
	reg [1:0] aspm_ctrl;

	// ASPM field kept apart: it alone feeds the transmit gating below
	always @(posedge clk_sys) begin
		if (reset) begin
			aspm_ctrl <= `PDSL_LC_ASPM_RST;
		end else if (wr_ctrl) begin
			// Bits 2, 3 and the upper byte have no storage
			aspm_ctrl <= cfg_wdata[`PDSL_LC_ASPM_LSB +: 2];
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			link_disable <= 1'h0;
			retrain_link <= 1'h0;
			common_clock <= 1'h0;
			ext_synch    <= 1'h0;
		end else if (wr_ctrl) begin
			link_disable <= cfg_wdata[`PDSL_LC_DISABLE_BIT];
			retrain_link <= cfg_wdata[`PDSL_LC_RETRAIN_BIT];
			common_clock <= cfg_wdata[`PDSL_LC_CCLK_BIT];
			ext_synch    <= cfg_wdata[`PDSL_LC_EXTSYN_BIT];
		end
	end

	// ==========================================================
	// Controls toward the link logic, and the error status mirror
	// ==========================================================
	// Count chosen by the extended synch bit, else the normal count
	function [12:0] pick_count;
		input        ext;
		input [12:0] ext_val;
		input [12:0] norm_val;
		begin
			pick_count = ext ? ext_val : norm_val;
		end
	endfunction

	always @(posedge clk_sys) begin
		if (reset) begin
			aspm_l0s_enable <= 1'h0;
			aspm_l1_enable  <= 1'h0;
		end else begin
			aspm_l0s_enable <= aspm_ctrl[0];
			aspm_l1_enable  <= aspm_ctrl[1];
		end
	end

	// Transmit side is gated by the field; receive side is not
	always @(posedge clk_sys) begin
		if (reset) begin
			rx_l0s_allowed <= 1'h1;
		end else begin
			rx_l0s_allowed <= 1'h1;
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			fts_count <= FTS_NORM;
			ts1_count <= TS1_NORM;
		end else begin
			fts_count <= pick_count(ext_synch, `PDSL_FTS_EXT, FTS_NORM);
			ts1_count <= pick_count(ext_synch, `PDSL_TS1_EXT, TS1_NORM);
		end
	end

	// Mirror of the sticky flags for the error reporting logic
	always @(posedge clk_sys) begin
		if (reset) begin
			err_status <= 4'h0;
		end else begin
			err_status <= err_flags;
		end
	end

	// ==========================================================
	// Register words as software sees them
	// ==========================================================
	reg [31:0] status_word;
	reg [31:0] cap_word;
	reg [31:0] ctrl_word;
	reg [31:0] next_rdata;

	always @* begin
		status_word = 32'h0000_0000;
		// Lower half belongs to device control, outside this bank
		status_word[`PDSL_ST_UNSUP_BIT:`PDSL_ST_COR_BIT] = err_flags;
		status_word[`PDSL_ST_AUX_BIT]  = aux_power;
		status_word[`PDSL_ST_PEND_BIT] = `PDSL_ST_PEND_VAL;
	end

	always @* begin
		cap_word = 32'h0000_0000;
		cap_word[`PDSL_CAP_SPEED_LSB +: 4] = `PDSL_CAP_SPEED_VAL;
		cap_word[`PDSL_CAP_WIDTH_LSB +: 6] = `PDSL_CAP_WIDTH_VAL;
		cap_word[`PDSL_CAP_ASPM_LSB +: 2]  = cap_aspm;
		cap_word[`PDSL_CAP_L0S_LSB +: 3]   = cap_l0s;
		cap_word[`PDSL_CAP_L1_LSB +: 3]    = cap_l1;
		cap_word[`PDSL_CAP_PORT_LSB +: 8]  = `PDSL_CAP_PORT_VAL;
	end

	always @* begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[`PDSL_LC_ASPM_LSB +: 2] = aspm_ctrl;
		ctrl_word[`PDSL_LC_RCB_BIT]       = `PDSL_LC_RCB_VAL;
		ctrl_word[`PDSL_LC_DISABLE_BIT]   = link_disable;
		ctrl_word[`PDSL_LC_RETRAIN_BIT]   = retrain_link;
		ctrl_word[`PDSL_LC_CCLK_BIT]      = common_clock;
		ctrl_word[`PDSL_LC_EXTSYN_BIT]    = ext_synch;
	end

	// ==========================================================
	// Read path
	// ==========================================================
	// Unmapped offsets answer with zero rather than being refused
	always @* begin
		next_rdata = 32'h0000_0000;
		if (sel_status) begin
			next_rdata = status_word;
		end else if (sel_cap) begin
			next_rdata = cap_word;
		end else if (sel_ctrl) begin
			next_rdata = ctrl_word;
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			cfg_rdata    <= 32'h0000_0000;
			cfg_rd_valid <= 1'h0;
		end else begin
			cfg_rd_valid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= next_rdata;
			end
		end
	end

endmodule

// file: rtl/pdsl_regs_pad.v
// Holds no logic; the bank lives in the main register file, its error flags in the sticky flag module

// file: rtl/pdsl_sticky_flags.v
// Bank of sticky event flags, cleared by writing one
module pdsl_sticky_flags #(
	parameter W = 4
) (
	input  wire         clk_sys,
	input  wire         reset,
	input  wire [W-1:0] set_pulse,
	input  wire         clr_en,
	input  wire [W-1:0] clr_mask,
	output reg  [W-1:0] flags
);

	wire [W-1:0] clr_eff;
	wire [W-1:0] next_flags;

	assign clr_eff    = clr_en ? clr_mask : {W{1'h0}};
	// Set is applied after the clear so a same-cycle event survives
	assign next_flags = (flags & ~clr_eff) | set_pulse;

	always @(posedge clk_sys) begin
		if (reset) begin
			flags <= {W{1'h0}};
		end else begin
			flags <= next_flags;
		end
	end

endmodule

// file: tb/pdsl_checker.sv
// Assertion checker for the status and link register bank
module pdsl_checker #(
	parameter [12:0] FTS_NORM = 13'h0080,
	parameter [12:0] TS1_NORM = 13'h0010
) (
	input wire        clk_sys,
	input wire        reset,
	input wire        cfg_wr,
	input wire        cfg_rd,
	input wire [11:0] cfg_addr,
	input wire [3:0]  cfg_be,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire        cfg_rd_valid,
	input wire        err_cor,
	input wire        aspm_l0s_enable,
	input wire        aspm_l1_enable,
	input wire        rx_l0s_allowed,
	input wire        common_clock,
	input wire        ext_synch,
	input wire [12:0] fts_count,
	input wire [12:0] ts1_count,
	input wire [3:0]  err_status
);
	timeunit 1ns;
	timeprecision 1ns;
	wire st_wr  = cfg_wr && cfg_be[2] && cfg_addr[11:2] == 10'h03A;
	wire ctl_wr = cfg_wr && cfg_be[0] && cfg_addr[11:2] == 10'h03C;
	wire st_rd  = cfg_rd && cfg_addr[11:2] == 10'h03A;
	wire cap_rd = cfg_rd && cfg_addr[11:2] == 10'h03B;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	a_rx_l0s_on: assert property (rx_l0s_allowed)
		else $error("rx L0s dropped");
	a_fts_select: assert property (fts_count == ($past(ext_synch) ? 13'h1000 : FTS_NORM))
		else $error("fts count");
	a_ts1_select: assert property (ts1_count == ($past(ext_synch) ? 13'h0400 : TS1_NORM))
		else $error("ts1 count");
	a_err_logged: assert property (err_cor |-> ##2 err_status[0])
		else $error("error not logged");
	a_err_cleared: assert property (st_wr && cfg_wdata[16] && !err_cor |-> ##2 !err_status[0])
		else $error("error not cleared");
	a_aspm_follow: assert property (ctl_wr |-> ##2
		{aspm_l1_enable, aspm_l0s_enable} == $past(cfg_wdata[1:0], 2))
		else $error("aspm enables");
	a_cclk_bit: assert property (ctl_wr |=> common_clock == $past(cfg_wdata[6]))
		else $error("common clock bit");
	a_cap_fixed: assert property (cap_rd |=> cfg_rdata[9:0] == 10'h011 && cfg_rdata[31:18] == 14'h0)
		else $error("fixed caps");
	a_status_zero: assert property (st_rd |=> cfg_rdata[31:21] == 11'h0 && cfg_rdata[15:0] == 16'h0)
		else $error("status reserved");
	a_rd_answer: assert property (cfg_rd_valid == $past(cfg_rd))
		else $error("read answer timing");
endmodule

bind pdsl_regs pdsl_checker #(.FTS_NORM(FTS_NORM), .TS1_NORM(TS1_NORM)) pdsl_checker_inst (.*);

// file: tb/pdsl_host.sv
// Configuration software model issuing dword reads and writes
module pdsl_host (
	input  wire         clk_sys,
	input  wire  [31:0] cfg_rdata,
	input  wire         cfg_rd_valid,
	output logic        cfg_wr,
	output logic        cfg_rd,
	output logic [11:0] cfg_addr,
	output logic [3:0]  cfg_be,
	output logic [31:0] cfg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 12'h000;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clk_sys);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
		// Idle data inverted so stale values never look valid
		cfg_wdata = ~d;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(negedge clk_sys);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk_sys);
		cfg_rd = 1'b0;
		cfg_addr = ~a;
		for (int i = 0; i < 4 && cfg_rd_valid !== 1'b1; i++)
			@(negedge clk_sys);
		d = cfg_rdata;
		if (cfg_rd_valid !== 1'b1) begin
			testbench.miscompares++;
			testbench.conclude();
		end
	endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the status and link register bank
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, reset, aux_power_det, cap_load;
	logic        err_cor, err_nonfatal, err_fatal, err_unsup;
	logic [1:0]  cap_aspm_in;
	logic [2:0]  cap_l0s_in, cap_l1_in;
	logic        cfg_wr, cfg_rd;
	logic [11:0] cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, rd_data;
	wire  [31:0] cfg_rdata;
	wire         cfg_rd_valid, aspm_l0s_enable, aspm_l1_enable, rx_l0s_allowed;
	wire         link_disable, retrain_link, common_clock, ext_synch;
	wire  [12:0] fts_count, ts1_count;
	wire  [3:0]  err_status;
	int          miscompares, check_count;
	pdsl_regs pdsl_regs_inst (.*);
	pdsl_host pdsl_host_inst (.*);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		if (g !== e)
			miscompares++;
	endtask
	task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
		pdsl_host_inst.rd(a, rd_data);
		chk(n, e, rd_data);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic t_reset();
		rdchk("status", 12'h0E8, 32'h0010_0000);
		rdchk("caps", 12'h0EC, 32'h0000_3411);
		rdchk("control", 12'h0F0, 32'h0000_0000);
		rdchk("unmapped", 12'h0F4, 32'h0000_0000);
		$display("reset test done");
	endtask
	task automatic t_err();
		@(negedge clk_sys);
		{err_unsup, err_fatal, err_nonfatal, err_cor} = 4'hF;
		@(negedge clk_sys);
		{err_unsup, err_fatal, err_nonfatal, err_cor} = 4'h0;
		rdchk("logged", 12'h0E8, 32'h001F_0000);
		pdsl_host_inst.wr(12'h0E8, 4'hB, 32'hFFFF_FFFF);
		rdchk("lane gated", 12'h0E8, 32'h001F_0000);
		pdsl_host_inst.wr(12'h0E8, 4'h4, 32'h000A_0000);
		rdchk("part clear", 12'h0E8, 32'h0015_0000);
		chk("err lines", 32'h5, {28'h0, err_status});
		aux_power_det = 1'b0;
		pdsl_host_inst.wr(12'h0E8, 4'hF, 32'hFFFF_FFFF);
		rdchk("clear aux", 12'h0E8, 32'h0000_0000);
		$display("error test done");
	endtask
	task automatic t_ctrl();
		for (int m = 0; m < 4; m++) begin
			pdsl_host_inst.wr(12'h0F0, 4'hF, {30'h3FFF_FFFF, m[1:0]});
			rdchk("control", 12'h0F0, {24'h0, 6'h3C, m[1:0]});
			chk("aspm", {30'h0, m[1:0]}, {30'h0, aspm_l1_enable, aspm_l0s_enable});
			chk("rx l0s", 32'h1, {31'h0, rx_l0s_allowed});
			chk("fts", 32'h1000, {19'h0, fts_count});
			chk("ts1", 32'h0400, {19'h0, ts1_count});
			chk("ctl pins", 32'hF, {28'h0, ext_synch, common_clock, retrain_link, link_disable});
		end
		pdsl_host_inst.wr(12'h0F0, 4'hE, 32'h0);
		rdchk("ctl gated", 12'h0F0, 32'h0000_00F3);
		pdsl_host_inst.wr(12'h0F0, 4'h1, 32'h0);
		rdchk("ctl clear", 12'h0F0, 32'h0000_0000);
		chk("fts norm", 32'h0080, {19'h0, fts_count});
		chk("ts1 norm", 32'h0010, {19'h0, ts1_count});
		chk("pins off", 32'h0, {28'h0, ext_synch, common_clock, retrain_link, link_disable});
		$display("control test done");
	endtask
	task automatic t_load();
		pdsl_host_inst.wr(12'h0EC, 4'hF, 32'hFFFF_FFFF);
		rdchk("caps ro", 12'h0EC, 32'h0000_3411);
		@(negedge clk_sys);
		cap_load = 1'b1;
		cap_aspm_in = 2'h2;
		cap_l0s_in = 3'h5;
		cap_l1_in = 3'h6;
		@(negedge clk_sys);
		cap_load = 1'b0;
		rdchk("loaded", 12'h0EC, 32'h0003_5811);
		$display("loader test done");
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		reset = 1'b1;
		aux_power_det = 1'b1;
		{err_unsup, err_fatal, err_nonfatal, err_cor} = 4'h0;
		{cap_load, cap_aspm_in, cap_l0s_in, cap_l1_in} = 9'h000;
		repeat (6) @(negedge clk_sys);
		reset = 1'b0;
		t_reset();
		t_err();
		t_ctrl();
		t_load();
		conclude();
	end
endmodule
